// *** core/dpc_cmd_mem.sv ***
/*
  Small memory that keeps the last executed command code of every domain.
  Assumes one writer per cycle and the caller's clock enable and reset.
*/
`timescale 1ns/1ps
module dpc_cmd_mem
  import dpc_pkg::*;
(
  input  wire logic                      MCLK,
  input  wire logic                      RST_B,
  input  wire logic                      CE,
  input  wire logic                      WE,
  input  wire logic [dpc_pkg::DOM_W-1:0] WADDR,
  input  wire logic [dpc_pkg::CMD_W-1:0] WDATA,
  input  wire logic [dpc_pkg::DOM_W-1:0] RADDR,
  output      logic [dpc_pkg::CMD_W-1:0] RDATA
);
  import dpc_pkg::*;

  // All memory state in one struct
  typedef struct packed {
    logic [NUM_DOMAINS-1:0][CMD_W-1:0] mem;  // Stored codes
    logic [CMD_W-1:0]                  rd;   // Registered read data
  } dpc_mem_state_type;

  dpc_mem_state_type s_q;  // Present state
  dpc_mem_state_type s_d;  // Next state

  ////////////////////////////////////////////////////////////////////////////
  // Write port and registered read port
  always_comb begin
    s_d = s_q;
    if (RADDR <= LAST_DOMAIN) begin
      s_d.rd = s_q.mem[RADDR];
    end
    if (WE && (WADDR <= LAST_DOMAIN)) begin
      s_d.mem[WADDR] = WDATA;
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      s_q <= '0;
    end else if (CE) begin
      s_q <= s_d;
    end
  end

  assign RDATA = s_q.rd;

endmodule

// *** core/dpc_pkg.sv ***
/*
  Package of the domain power command register block: register offsets,
  command and sequencer codes, bus carrier structs and state encodings.
  Assumes a single controller clock and a 16-bit byte address on the bus.
*/
// Function
// - Debug copy fixed; cores at base plus stride
// - Coherence-manager copy ignores every write
// - Coherence-manager copy always reads zero
// - Command field write requests new sequence
// - Read returns last executed command code
// - Reset value follows cold power-up input
// - Clock-off gates the domain clock
// - Clock-off waits for coherence and interlocks
// - Clock-off on unpowered domain stops clock-gated
// - Power-down waits coherence off, interlocks clear
// - Power-up acts like hardware power-on input
// - Reset only when domain is non-coherent
// - Completed reset reads back as power-up
// - Reserved command codes are never loaded
// - Clock-gated state is 3, reset state 4
package dpc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int unsigned NUM_CORES   = 64;              // Core domains
  localparam int unsigned NUM_DOMAINS = NUM_CORES + 1;   // Cores plus debug
  localparam int unsigned DOM_W       = 7;               // Domain index width
  localparam int unsigned ADDR_W      = 16;              // Byte address width
  localparam int unsigned DATA_W      = 32;              // Bus data width
  localparam int unsigned CMD_W       = 4;               // Command field width
  localparam int unsigned BE_W        = 4;               // Byte enables

  localparam logic [DOM_W-1:0] DEBUG_DOMAIN = 7'h40;     // Debug copy index
  localparam logic [DOM_W-1:0] LAST_DOMAIN  = 7'h40;     // Highest index

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_DEBUG_CMD     = 16'h9100;
  localparam logic [ADDR_W-1:0] OFS_CORE_CMD_BASE = 16'ha000;
  localparam logic [ADDR_W-1:0] OFS_CORE_STRIDE   = 16'h0100;
  localparam logic [ADDR_W-1:0] OFS_CM_CMD        = 16'h9000;
  localparam logic [ADDR_W-1:0] OFS_CORE_CMD_LAST =
    OFS_CORE_CMD_BASE + OFS_CORE_STRIDE * 16'(NUM_CORES - 1);

  // Command field position inside the register
  localparam int unsigned CMD_LSB = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Command codes
  localparam logic [CMD_W-1:0] CMD_GATE_CLOCK = 4'h1;    // gate_clock_request
  localparam logic [CMD_W-1:0] CMD_POWER_OFF  = 4'h2;    // power_off_request
  localparam logic [CMD_W-1:0] CMD_POWER_ON   = 4'h3;    // power_on_request
  localparam logic [CMD_W-1:0] CMD_RESET      = 4'h4;    // Reset request

  // Field values loaded after controller reset
  localparam logic [CMD_W-1:0] CMD_RESET_COLD_ON  = CMD_POWER_ON;
  localparam logic [CMD_W-1:0] CMD_RESET_COLD_OFF = CMD_POWER_OFF;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer target states reported per executed command
  localparam logic [3:0] SEQ_POWERED_DOWN             = 4'h0;
  localparam logic [3:0] SEQ_POWERED_CLOCK_GATED_STATE = 4'h3;
  localparam logic [3:0] SEQ_HELD_IN_RESET_STATE      = 4'h4;
  localparam logic [3:0] SEQ_NON_COHERENT             = 4'h6;

  // Cycles the cold input synchroniser needs before its value is used
  localparam logic [1:0] SYNC_SETTLE_CYCLES = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Carrier types
  typedef struct packed {
    logic              read;
    logic              write;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] writedata;
    logic [BE_W-1:0]   byteenable;
  } dpc_avalon_req_type;

  typedef struct packed {
    logic             valid;   // One-cycle execution pulse
    logic [DOM_W-1:0] domain;  // Domain that executed
    logic [CMD_W-1:0] cmd;     // Code executed
    logic [3:0]       state;   // Sequencer state entered
  } dpc_exec_type;

  // Bus access states, Gray along init, idle, access, done
  typedef enum logic [1:0] {
    BUS_INIT   = 2'b10,
    BUS_IDLE   = 2'b00,
    BUS_ACCESS = 2'b01,
    BUS_DONE   = 2'b11
  } dpc_bus_state_type;

endpackage

// *** core/dpc_power_cmd.sv ***
/*
  Per-domain power command registers for the debug domain and 64 cores,
  reached over an Avalon-MM slave with waitrequest. Accepted commands are
  held pending per domain and issued to the outside sequencer once their
  interlocks allow; the register reads back the last executed code.
  Assumes coherence, interlock and mode inputs come from logic on MCLK,
  while the cold power-up levels arrive from pins.
*/
`timescale 1ns/1ps
module dpc_power_cmd
  import dpc_pkg::*;
(
  input  wire logic                             MCLK,
  input  wire logic                             RST_B,
  input  wire logic                             CE,
  input  wire dpc_pkg::dpc_avalon_req_type      AV_REQ,
  output      logic                             AV_WAITREQUEST,
  output      logic [dpc_pkg::DATA_W-1:0]       AV_READDATA,
  input  wire logic [dpc_pkg::NUM_DOMAINS-1:0]  COLD_POWER_ON_IN,
  input  wire logic [dpc_pkg::NUM_DOMAINS-1:0]  COHERENCE_EN,
  input  wire logic [dpc_pkg::NUM_DOMAINS-1:0]  INTERLOCK_CLEAR,
  input  wire logic [dpc_pkg::NUM_DOMAINS-1:0]  NON_COHERENT,
  output      dpc_pkg::dpc_exec_type            EXEC,
  output      logic [dpc_pkg::NUM_DOMAINS-1:0]  DOMAIN_CLK_EN,
  output      logic [dpc_pkg::NUM_DOMAINS-1:0]  DOMAIN_POWERED
);
  import dpc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State of the block, one packed struct

  typedef struct packed {
    dpc_bus_state_type                 bus;       // Bus access state
    logic [DATA_W-1:0]                 rd;        // Read data to master
    logic                              rd_zero;   // Read answers zero
    logic [DOM_W-1:0]                  init_idx;  // Reset-value walker
    logic [1:0]                        settle;    // Synchroniser settle count
    logic [NUM_DOMAINS-1:0]            sync1;     // Cold input, first stage
    logic [NUM_DOMAINS-1:0]            sync2;     // Cold input, second stage
    logic [NUM_DOMAINS-1:0]            pend_v;    // Command pending
    logic [NUM_DOMAINS-1:0][CMD_W-1:0] pend_cmd;  // Pending code
    logic [DOM_W-1:0]                  ptr;       // Executor scan position
    dpc_exec_type                      exec;      // Execution report
    logic [NUM_DOMAINS-1:0]            clk_en;    // Domain clock enabled
    logic [NUM_DOMAINS-1:0]            powered;   // Domain powered
  } dpc_main_state_type;

  dpc_main_state_type s_q;  // Present state
  dpc_main_state_type s_d;  // Next state

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  logic [ADDR_W-1:0] core_ofs;    // Offset into core copies
  logic              hit_core;    // A core copy is addressed
  logic              hit_debug;   // The debug copy is addressed
  logic              hit_cm;      // Coherence-manager copy
  logic [DOM_W-1:0]  dom_idx;     // Domain of the access

  // Find which copy, if any, the address names
  always_comb begin
    core_ofs  = AV_REQ.address - OFS_CORE_CMD_BASE;
    hit_debug = (AV_REQ.address == OFS_DEBUG_CMD);
    hit_cm    = (AV_REQ.address == OFS_CM_CMD);
    hit_core  = (AV_REQ.address >= OFS_CORE_CMD_BASE) &&
                (AV_REQ.address <= OFS_CORE_CMD_LAST) &&
                ((core_ofs % OFS_CORE_STRIDE) == '0);
    if (hit_debug) begin
      dom_idx = DEBUG_DOMAIN;
    end else begin
      dom_idx = DOM_W'(core_ofs / OFS_CORE_STRIDE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Executed-code memory

  logic             mem_we;     // Write an executed code
  logic [DOM_W-1:0] mem_waddr;  // Domain written
  logic [CMD_W-1:0] mem_wdata;  // Code written
  logic [CMD_W-1:0] mem_rdata;  // Code read back

  dpc_cmd_mem u_mem (
    .MCLK  (MCLK),
    .RST_B (RST_B),
    .CE    (CE),
    .WE    (mem_we),
    .WADDR (mem_waddr),
    .WDATA (mem_wdata),
    .RADDR (dom_idx),
    .RDATA (mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Command gating for the domain under the scan pointer

  logic [CMD_W-1:0] cur_cmd;   // Pending code at the pointer
  logic             allowed;   // Interlocks let it run
  logic             fire;      // Execute this cycle
  logic             wr_ok;     // Bus write carries a loadable code
  logic [CMD_W-1:0] wr_cmd;    // Code in the written field

  always_comb begin
    cur_cmd = s_q.pend_cmd[s_q.ptr];
    unique case (cur_cmd)
      CMD_GATE_CLOCK: begin
        // Held back while coherent or interlocked
        allowed = !COHERENCE_EN[s_q.ptr] && INTERLOCK_CLEAR[s_q.ptr];
      end
      CMD_POWER_OFF: begin
        // Needs coherence off and interlocks clear
        allowed = !COHERENCE_EN[s_q.ptr] && INTERLOCK_CLEAR[s_q.ptr];
      end
      CMD_POWER_ON: begin
        // Always runs, like the hardware power-on input
        allowed = 1'b1;
      end
      CMD_RESET: begin
        // Only a non-coherent domain may be reset
        allowed = NON_COHERENT[s_q.ptr];
      end
      default: begin
        allowed = 1'b0;
      end
    endcase
    fire   = (s_q.bus != BUS_INIT) && s_q.pend_v[s_q.ptr] && allowed;
    wr_cmd = AV_REQ.writedata[CMD_LSB +: CMD_W];
    // Only codes one to four load, and only through byte lane 0
    wr_ok  = AV_REQ.byteenable[0] &&
             (wr_cmd >= CMD_GATE_CLOCK) && (wr_cmd <= CMD_RESET);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    s_d            = s_q;
    s_d.exec.valid = 1'b0;
    s_d.sync1      = COLD_POWER_ON_IN;
    s_d.sync2      = s_q.sync1;
    mem_we         = 1'b0;
    mem_waddr      = s_q.ptr;
    mem_wdata      = cur_cmd;

    // Executor: visits one domain per cycle once initialised
    if (s_q.bus != BUS_INIT) begin
      s_d.ptr = (s_q.ptr == LAST_DOMAIN) ? '0 : s_q.ptr + 7'h01;
    end
    if (fire) begin
      s_d.pend_v[s_q.ptr] = 1'b0;
      s_d.exec.valid      = 1'b1;
      s_d.exec.domain     = s_q.ptr;
      s_d.exec.cmd        = cur_cmd;
      mem_we              = 1'b1;
      unique case (cur_cmd)
        CMD_GATE_CLOCK: begin
          // Unpowered domains power up and stop clock-gated
          s_d.clk_en[s_q.ptr]  = 1'b0;
          s_d.powered[s_q.ptr] = 1'b1;
          s_d.exec.state       = SEQ_POWERED_CLOCK_GATED_STATE;
        end
        CMD_POWER_OFF: begin
          // Remove clock and power
          s_d.clk_en[s_q.ptr]  = 1'b0;
          s_d.powered[s_q.ptr] = 1'b0;
          s_d.exec.state       = SEQ_POWERED_DOWN;
        end
        CMD_POWER_ON: begin
          // Power and clock the domain
          s_d.clk_en[s_q.ptr]  = 1'b1;
          s_d.powered[s_q.ptr] = 1'b1;
          s_d.exec.state       = SEQ_NON_COHERENT;
        end
        CMD_RESET: begin
          // Domain passes reset and becomes operational
          s_d.clk_en[s_q.ptr]  = 1'b1;
          s_d.powered[s_q.ptr] = 1'b1;
          s_d.exec.state       = SEQ_HELD_IN_RESET_STATE;
          mem_wdata            = CMD_POWER_ON;
        end
        default: begin
          s_d.exec.state = s_q.exec.state;
        end
      endcase
    end

    // Bus access and reset-value walk
    unique case (s_q.bus)
      BUS_INIT: begin
        if (s_q.settle != SYNC_SETTLE_CYCLES) begin
          // Let the cold input synchroniser fill
          s_d.settle = s_q.settle + 2'h1;
        end else begin
          // Load each domain's field from its cold input
          mem_we    = 1'b1;
          mem_waddr = s_q.init_idx;
          mem_wdata = s_q.sync2[s_q.init_idx] ? CMD_RESET_COLD_ON
                                              : CMD_RESET_COLD_OFF;
          s_d.powered[s_q.init_idx] = s_q.sync2[s_q.init_idx];
          s_d.clk_en[s_q.init_idx]  = s_q.sync2[s_q.init_idx];
          if (s_q.init_idx == LAST_DOMAIN) begin
            s_d.bus = BUS_IDLE;
          end else begin
            s_d.init_idx = s_q.init_idx + 7'h01;
          end
        end
      end
      BUS_IDLE: begin
        if (AV_REQ.read) begin
          // Memory read issued now, data valid next cycle
          s_d.rd_zero = !(hit_core || hit_debug);
          s_d.bus     = BUS_ACCESS;
        end else if (AV_REQ.write) begin
          // A loadable code becomes pending; the bus set wins over clear
          if ((hit_core || hit_debug) && wr_ok) begin
            s_d.pend_v[dom_idx]   = 1'b1;
            s_d.pend_cmd[dom_idx] = wr_cmd;
          end
          // Coherence-manager and unmapped writes fall through unused
          s_d.bus = BUS_DONE;
        end
      end
      BUS_ACCESS: begin
        // Field in the low bits, upper bits zero
        if (s_q.rd_zero) begin
          s_d.rd = '0;
        end else begin
          s_d.rd = {{(DATA_W - CMD_W){1'b0}}, mem_rdata};
        end
        s_d.bus = BUS_DONE;
      end
      BUS_DONE: begin
        // Answer stands for this single cycle
        s_d.bus = BUS_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register, frozen while the clock enable is low

  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      s_q     <= '0;
      s_q.bus <= BUS_INIT;
    end else if (CE) begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Answer given only in the done state
  assign AV_WAITREQUEST = (s_q.bus != BUS_DONE);
  assign AV_READDATA    = s_q.rd;
  assign EXEC           = s_q.exec;
  assign DOMAIN_CLK_EN  = s_q.clk_en;
  assign DOMAIN_POWERED = s_q.powered;

endmodule

// *** testbench/dpc_power_cmd_properties.sv ***
/*
  Concurrent checks on the ports of the domain power command block.
  Assumes it is bound into dpc_power_cmd and sees only its ports.
*/
`timescale 1ns/1ps
module dpc_power_cmd_properties
  import dpc_pkg::*;
(
  input wire logic                            MCLK,
  input wire logic                            RST_B,
  input wire dpc_pkg::dpc_avalon_req_type     AV_REQ,
  input wire logic                            AV_WAITREQUEST,
  input wire logic [dpc_pkg::DATA_W-1:0]      AV_READDATA,
  input wire logic [dpc_pkg::NUM_DOMAINS-1:0] COHERENCE_EN,
  input wire logic [dpc_pkg::NUM_DOMAINS-1:0] INTERLOCK_CLEAR,
  input wire logic [dpc_pkg::NUM_DOMAINS-1:0] NON_COHERENT,
  input wire dpc_pkg::dpc_exec_type           EXEC,
  input wire logic [dpc_pkg::NUM_DOMAINS-1:0] DOMAIN_CLK_EN,
  input wire logic [dpc_pkg::NUM_DOMAINS-1:0] DOMAIN_POWERED
);
  import dpc_pkg::*;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_B);
  ////////////////////////////////////////////////////////////
  // Gate inputs as seen in the cycle the executor decided
  logic [NUM_DOMAINS-1:0] coh_q;  // Coherence one cycle back
  logic [NUM_DOMAINS-1:0] ilk_q;  // Interlocks one cycle back
  logic [NUM_DOMAINS-1:0] nc_q;   // Non-coherent one cycle back
  always_ff @(posedge MCLK) begin
    coh_q <= COHERENCE_EN;
    ilk_q <= INTERLOCK_CLEAR;
    nc_q  <= NON_COHERENT;
  end
  ////////////////////////////////////////////////////////////
  // Bus steps
  sequence bus_done;
    (AV_REQ.read || AV_REQ.write) && !AV_WAITREQUEST;
  endsequence
  sequence wr_raised;
    $rose(AV_REQ.write);
  endsequence
  // Executed command steps
  sequence ran(c);
    EXEC.valid && EXEC.cmd == c;
  endsequence
  ////////////////////////////////////////////////////////////
  AST_WAIT_ONE: assert property (bus_done |=> AV_WAITREQUEST)
    else $error("waitrequest low longer than one cycle");
  AST_WR_ANSWER: assert property (wr_raised |-> ##[0:120] !AV_WAITREQUEST)
    else $error("write never answered");
  AST_CODE_LEGAL: assert property (EXEC.valid |-> EXEC.cmd inside {[4'h1:4'h4]})
    else $error("reserved code executed");
  AST_GATE_WAIT: assert property (ran(CMD_GATE_CLOCK) or ran(CMD_POWER_OFF)
    |-> !coh_q[EXEC.domain] && ilk_q[EXEC.domain])
    else $error("clock-off or power-down ran past its barriers");
  AST_CLK_OFF: assert property (ran(CMD_GATE_CLOCK) |-> EXEC.state == 4'h3
    && !DOMAIN_CLK_EN[EXEC.domain] && DOMAIN_POWERED[EXEC.domain])
    else $error("clock-off result wrong");
  AST_PWR_OFF: assert property (ran(CMD_POWER_OFF) |-> !DOMAIN_POWERED[EXEC.domain])
    else $error("power-down left domain powered");
  AST_PWR_ON: assert property (ran(CMD_POWER_ON) |-> DOMAIN_POWERED[EXEC.domain])
    else $error("power-up left domain unpowered");
  AST_RESET_NC: assert property (ran(CMD_RESET) |-> nc_q[EXEC.domain] && EXEC.state == 4'h4)
    else $error("reset ran on coherent domain");
  AST_UPPER_ZERO: assert property (bus_done and AV_REQ.read |-> AV_READDATA[31:4] == 28'h0)
    else $error("upper bits read nonzero");
  AST_INERT_ZERO: assert property (bus_done and AV_REQ.read && AV_REQ.address == OFS_CM_CMD
    |-> AV_READDATA == 32'h0)
    else $error("inert copy read nonzero");
endmodule

// *** testbench/tb.sv ***
/*
  Self-checking bench of the domain power command block over Avalon-MM.
  Assumes the package and design files are compiled first.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; \
  $display("Error %0t: got %h expected %h", $time, a, b); end end
module tb;
  import dpc_pkg::*;
  logic                   mclk        = 1'b0;
  logic                   rst_b       = 1'b0;
  dpc_avalon_req_type     av_req      = '0;
  logic [NUM_DOMAINS-1:0] cold        = 65'h1_ffff_ffff_ffff_fffd;  // Core 1 cold-off
  logic [NUM_DOMAINS-1:0] coh         = '0;
  logic [NUM_DOMAINS-1:0] ilk         = '1;
  logic [NUM_DOMAINS-1:0] ncoh        = '1;
  logic                   wait_req;
  logic [DATA_W-1:0]      rdata;
  dpc_exec_type           exec;
  logic [NUM_DOMAINS-1:0] clk_en;
  logic [NUM_DOMAINS-1:0] powered;
  int                     num_errors  = 0;
  int                     checks_done = 0;
  int                     exec_n    [NUM_DOMAINS] = '{default: 0};  // Executions seen per domain
  int                     used_n    [NUM_DOMAINS] = '{default: 0};  // Executions already judged
  logic [3:0]             exec_last [NUM_DOMAINS];                  // Last code executed per domain
  always #2 mclk = ~mclk;
  // Records every execution pulse, which stands for only one cycle
  always @(posedge mclk) begin
    if (exec.valid === 1'b1) begin
      exec_n[exec.domain]    <= exec_n[exec.domain] + 1;
      exec_last[exec.domain] <= exec.cmd;
    end
  end
  dpc_power_cmd i_dut (.MCLK(mclk), .RST_B(rst_b), .CE(1'b1), .AV_REQ(av_req), .AV_WAITREQUEST(wait_req),
    .AV_READDATA(rdata), .COLD_POWER_ON_IN(cold), .COHERENCE_EN(coh), .INTERLOCK_CLEAR(ilk),
    .NON_COHERENT(ncoh), .EXEC(exec), .DOMAIN_CLK_EN(clk_en), .DOMAIN_POWERED(powered));
  ////////////////////////////////////////////////////////////
  // One Avalon access; request held to the edge that sees waitrequest low
  task automatic bus(input logic rd, input logic [15:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    av_req <= '{read: rd, write: !rd, address: a, writedata: d, byteenable: 4'hf};
    do begin
      @(posedge mclk);
      n++;
    end while (wait_req !== 1'b0 && n < 300);
    q = rdata;
    av_req <= '0;
    if (n >= 300) begin
      num_errors++;
      $display("Error %0t: bus timeout", $time);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b0, a, d, q);
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b1, a, 32'h0, q);
    `CHK(q, e)
  endtask
  // Waits for the executor to report a domain, then checks its code
  task automatic wait_exec(input logic [6:0] dom, input logic [3:0] c);
    int n;
    n = 0;
    while (exec_n[dom] == used_n[dom] && n < 400) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 400) begin
      num_errors++;
      $display("Error %0t: execution timeout", $time);
    end
    used_n[dom] = exec_n[dom];
    `CHK(exec_last[dom], c)
  endtask
  function automatic logic [15:0] core(input int i);
    return OFS_CORE_CMD_BASE + OFS_CORE_STRIDE * 16'(i);
  endfunction
  ////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset_values;
    rd_chk(core(0), 32'h3);
    rd_chk(core(1), 32'h2);
    rd_chk(OFS_DEBUG_CMD, 32'h3);
    `CHK(powered[1], 1'b0)
  endtask
  task automatic t_codes;
    for (int c = 1; c <= 4; c++) begin
      wr(core(5), 32'(c));
      wait_exec(7'd5, 4'(c));
      rd_chk(core(5), (c == 4) ? 32'h3 : 32'(c));
    end
    wr(OFS_DEBUG_CMD, 32'h1);
    wait_exec(DEBUG_DOMAIN, CMD_GATE_CLOCK);
    rd_chk(OFS_DEBUG_CMD, 32'h1);
  endtask
  task automatic t_reserved;
    wr(core(5), 32'h0);
    wr(core(5), 32'h5);
    wr(core(5), 32'hf);
    repeat (150) @(posedge mclk);
    rd_chk(core(5), 32'h3);
    wr(core(5), 32'hffff_fff2);
    wait_exec(7'd5, CMD_POWER_OFF);
    rd_chk(core(5), 32'h2);
  endtask
  task automatic t_barriers;
    @(posedge mclk);
    coh[7]  <= 1'b1;
    ilk[8]  <= 1'b0;
    ncoh[9] <= 1'b0;
    wr(core(7), 32'h1);
    wr(core(8), 32'h2);
    wr(core(9), 32'h4);
    repeat (150) @(posedge mclk);
    rd_chk(core(7), 32'h3);
    rd_chk(core(8), 32'h3);
    rd_chk(core(9), 32'h3);
    @(posedge mclk);
    coh[7] <= 1'b0;
    wait_exec(7'd7, CMD_GATE_CLOCK);
    @(posedge mclk);
    ilk[8] <= 1'b1;
    wait_exec(7'd8, CMD_POWER_OFF);
    @(posedge mclk);
    ncoh[9] <= 1'b1;
    wait_exec(7'd9, CMD_RESET);
    rd_chk(core(9), 32'h3);
    wr(core(8), 32'h1);
    wait_exec(7'd8, CMD_GATE_CLOCK);
    `CHK(powered[8], 1'b1)
    `CHK(clk_en[8], 1'b0)
  endtask
  task automatic t_mapping;
    wr(OFS_CM_CMD, 32'h2);
    rd_chk(OFS_CM_CMD, 32'h0);
    rd_chk(core(0), 32'h3);
    rd_chk(16'ha008, 32'h0);
    wr(core(63), 32'h2);
    wait_exec(7'd63, CMD_POWER_OFF);
    rd_chk(core(63), 32'h2);
  endtask
  ////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic final_report;
    $display("Checks %0d, errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #60000;
    num_errors++;
    $display("Error %0t: watchdog expired", $time);
    final_report();
  end
  initial begin
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    t_reset_values();
    t_codes();
    t_reserved();
    t_barriers();
    t_mapping();
    final_report();
  end
endmodule
bind dpc_power_cmd dpc_power_cmd_properties i_props (.MCLK(MCLK), .RST_B(RST_B), .AV_REQ(AV_REQ),
  .AV_WAITREQUEST(AV_WAITREQUEST), .AV_READDATA(AV_READDATA), .COHERENCE_EN(COHERENCE_EN),
  .INTERLOCK_CLEAR(INTERLOCK_CLEAR), .NON_COHERENT(NON_COHERENT), .EXEC(EXEC),
  .DOMAIN_CLK_EN(DOMAIN_CLK_EN), .DOMAIN_POWERED(DOMAIN_POWERED));
